/* File: hw/nco_pkg.sv */
package nco_pkg;
    localparam int ACC_W     = 28;
    localparam int PHASE_W   = 12;
    localparam int DAC_W     = 10;
    localparam int PH_LSB    = ACC_W - PHASE_W;
    localparam int BYP_LSB   = PHASE_W - DAC_W;
    localparam int ROM_DEPTH = 4096;
    localparam int SINE_AMP  = 511;
    localparam int SINE_MID  = 512;
    localparam int LAT_MIN   = 7;
    localparam int LAT_MAX   = 8;

    localparam logic [ACC_W-1:0]   ACC_CLEAR = 28'h0000000;
    localparam logic [PHASE_W-1:0] PH_CLEAR  = 12'h000;
    localparam logic [DAC_W-1:0]   DAC_MID   = 10'h200;
    localparam logic [DAC_W-1:0]   DAC_CLEAR = 10'h000;

    typedef logic [ACC_W-1:0]   acc_word_t;
    typedef logic [PHASE_W-1:0] phase_word_t;
    typedef logic [DAC_W-1:0]   dac_word_t;

    typedef struct packed {
        acc_word_t   freq_increment_a;
        acc_word_t   freq_increment_b;
        phase_word_t phase_offset_a;
        phase_word_t phase_offset_b;
        logic        freq_reg_select_bit;
        logic        phase_reg_select_bit;
        logic        datapath_reset;
    } nco_ctl_t;

    localparam nco_ctl_t CTL_CLEAR = '0;
endpackage : nco_pkg

/* File: hw/sine_table_rom.sv */
`timescale 1ns/1ps
module sine_table_rom #(
    parameter int ADDR_W = nco_pkg::PHASE_W,
    parameter int DATA_W = nco_pkg::DAC_W
) (
    input  wire logic              sys_clk_in,
    input  wire logic              rstn_in,
    input  wire logic              read_en_in,
    input  wire logic [ADDR_W-1:0] addr_in,
    output logic      [DATA_W-1:0] data_out
);
    logic [DATA_W-1:0] table_mem [0:(1<<ADDR_W)-1];

    // Offset-binary sine, midscale at phase zero
    initial begin
        for (int i = 0; i < (1 << ADDR_W); i++) begin
            table_mem[i] = DATA_W'($rtoi(nco_pkg::SINE_MID + nco_pkg::SINE_AMP
                           * $sin(6.283185307179586 * i / (1 << ADDR_W)) + 0.5));
        end
    end

    always_ff @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            data_out <= nco_pkg::DAC_MID;
        end else if (read_en_in) begin
            data_out <= table_mem[addr_in];
        end
    end
endmodule : sine_table_rom

/* File: hw/nco_phase_mod_sine_lookup.sv */
`timescale 1ns/1ps
module nco_phase_mod_sine_lookup (
    input  wire logic                sys_clk_in,
    input  wire logic                rstn_in,
    input  wire nco_pkg::nco_ctl_t   ctl_in,
    input  wire logic                sine_bypass_in,
    input  wire logic                dac_ready_in,
    output logic [nco_pkg::DAC_W-1:0] dac_sample_out,
    output logic                     dac_valid_out
);
    nco_pkg::nco_ctl_t    ctl_neg_reg;
    nco_pkg::acc_word_t   inc_reg;
    nco_pkg::acc_word_t   acc_reg;
    nco_pkg::acc_word_t   acc_next;
    nco_pkg::phase_word_t off_d1_reg;
    nco_pkg::phase_word_t off_d2_reg;
    nco_pkg::phase_word_t phase_reg;
    nco_pkg::phase_word_t phase_next;
    nco_pkg::phase_word_t addr_reg;
    nco_pkg::phase_word_t addr_d_reg;
    nco_pkg::dac_word_t   rom_q;
    nco_pkg::dac_word_t   samp_reg;
    nco_pkg::dac_word_t   samp_next;
    nco_pkg::dac_word_t   spare_reg;
    nco_pkg::dac_word_t   addr_hi;
    logic                 addr_v_reg;
    logic                 rom_v_reg;
    logic                 samp_v_reg;
    logic                 spare_v_reg;
    logic                 adv;
    logic                 head_load;
    logic                 dp_clear;

    // All ctl_in controls, select bits included, are captured on the falling edge
    always_ff @(negedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            ctl_neg_reg <= nco_pkg::CTL_CLEAR;
        end else begin
            ctl_neg_reg <= ctl_in;
        end
    end

    assign dp_clear   = ctl_neg_reg.datapath_reset;
    assign acc_next   = dp_clear ? nco_pkg::ACC_CLEAR : acc_reg + inc_reg;
    assign phase_next = dp_clear ? nco_pkg::PH_CLEAR
                      : acc_reg[nco_pkg::ACC_W-1:nco_pkg::PH_LSB] + off_d2_reg;
    assign addr_hi    = addr_reg[nco_pkg::PHASE_W-1:nco_pkg::BYP_LSB];
    assign samp_next  = sine_bypass_in
                      ? addr_d_reg[nco_pkg::PHASE_W-1:nco_pkg::BYP_LSB]
                      : rom_q;
    assign adv        = !spare_v_reg;
    assign head_load  = !dac_valid_out || dac_ready_in;

    // Increment and offset selection; accumulator is never reloaded here
    always_ff @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            inc_reg    <= nco_pkg::ACC_CLEAR;
            off_d1_reg <= nco_pkg::PH_CLEAR;
            off_d2_reg <= nco_pkg::PH_CLEAR;
        end else begin
            inc_reg    <= ctl_neg_reg.freq_reg_select_bit
                        ? ctl_neg_reg.freq_increment_b
                        : ctl_neg_reg.freq_increment_a;
            off_d1_reg <= ctl_neg_reg.phase_reg_select_bit
                        ? ctl_neg_reg.phase_offset_b
                        : ctl_neg_reg.phase_offset_a;
            off_d2_reg <= off_d1_reg;
        end
    end

    // Accumulator and phase adder run every clock; reset bit clears them
    always_ff @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            acc_reg   <= nco_pkg::ACC_CLEAR;
            phase_reg <= nco_pkg::PH_CLEAR;
        end else begin
            acc_reg   <= acc_next;
            phase_reg <= phase_next;
        end
    end

    // Lookup pipeline holds while the buffer is full
    always_ff @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            addr_reg   <= nco_pkg::PH_CLEAR;
            addr_d_reg <= nco_pkg::PH_CLEAR;
            samp_reg   <= nco_pkg::DAC_MID;
            addr_v_reg <= 1'b0;
            rom_v_reg  <= 1'b0;
            samp_v_reg <= 1'b0;
        end else if (adv) begin
            addr_reg   <= phase_reg;
            addr_d_reg <= addr_reg;
            samp_reg   <= samp_next;
            addr_v_reg <= 1'b1;
            rom_v_reg  <= addr_v_reg;
            samp_v_reg <= rom_v_reg;
        end
    end

    sine_table_rom #(
        .ADDR_W (nco_pkg::PHASE_W),
        .DATA_W (nco_pkg::DAC_W)
    ) u_sine_rom (
        .sys_clk_in (sys_clk_in),
        .rstn_in    (rstn_in),
        .read_en_in (adv),
        .addr_in    (addr_reg),
        .data_out   (rom_q)
    );

    // Two-entry buffer: head drives the DAC, spare catches a stalled word
    always_ff @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            dac_sample_out <= nco_pkg::DAC_MID;
            dac_valid_out  <= 1'b0;
        end else if (head_load) begin
            dac_sample_out <= spare_v_reg ? spare_reg : samp_reg;
            dac_valid_out  <= spare_v_reg || samp_v_reg;
        end
    end

    always_ff @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            spare_reg   <= nco_pkg::DAC_CLEAR;
            spare_v_reg <= 1'b0;
        end else if (head_load) begin
            spare_v_reg <= 1'b0;
        end else if (adv && samp_v_reg) begin
            spare_reg   <= samp_reg;
            spare_v_reg <= 1'b1;
        end
    end

    sequence s_two_adv;
        adv ##1 adv;
    endsequence

    sequence s_run;
        !dp_clear;
    endsequence

    chk_acc_step: assert property (
        @(posedge sys_clk_in) disable iff (!rstn_in)
        s_run |=> acc_reg == nco_pkg::ACC_W'($past(acc_reg) + $past(inc_reg)))
        else $error("accumulator did not advance by increment");

    chk_freq_select: assert property (
        @(posedge sys_clk_in) disable iff (!rstn_in)
        1'b1 |=> inc_reg == ($past(ctl_neg_reg.freq_reg_select_bit)
                 ? $past(ctl_neg_reg.freq_increment_b)
                 : $past(ctl_neg_reg.freq_increment_a)))
        else $error("wrong increment selected");

    chk_switch_continuous: assert property (
        @(posedge sys_clk_in) disable iff (!rstn_in)
        (s_run ##0 $changed(inc_reg)) |=> acc_reg != nco_pkg::ACC_CLEAR
            || $past(acc_reg) + $past(inc_reg) == nco_pkg::ACC_CLEAR)
        else $error("accumulator disturbed by frequency switch");

    chk_phase_add: assert property (
        @(posedge sys_clk_in) disable iff (!rstn_in)
        s_run |=> phase_reg == nco_pkg::PHASE_W'($past(acc_reg) >> nco_pkg::PH_LSB)
                  + $past(off_d2_reg))
        else $error("phase offset not added to MSBs");

    chk_offset_select: assert property (
        @(posedge sys_clk_in) disable iff (!rstn_in)
        1'b1 |=> ##1 off_d2_reg == ($past(ctl_neg_reg.phase_reg_select_bit, 2)
                 ? $past(ctl_neg_reg.phase_offset_b, 2)
                 : $past(ctl_neg_reg.phase_offset_a, 2)))
        else $error("wrong phase offset selected");

    chk_clear_zero: assert property (
        @(posedge sys_clk_in) disable iff (!rstn_in)
        dp_clear |=> acc_reg == nco_pkg::ACC_CLEAR && phase_reg == nco_pkg::PH_CLEAR)
        else $error("reset bit did not clear datapath");

    chk_rom_mid: assert property (
        @(posedge sys_clk_in) disable iff (!rstn_in)
        (adv && addr_reg == nco_pkg::PH_CLEAR) |=> rom_q == nco_pkg::DAC_MID)
        else $error("sine of zero phase not midscale");

    chk_bypass_path: assert property (
        @(posedge sys_clk_in) disable iff (!rstn_in)
        (s_two_adv ##0 sine_bypass_in) |=> samp_reg == $past(addr_hi, 2))
        else $error("bypass sample misaligned");

    chk_buf_hold: assert property (
        @(posedge sys_clk_in) disable iff (!rstn_in)
        (dac_valid_out && !dac_ready_in) |=> dac_valid_out && $stable(dac_sample_out))
        else $error("stalled sample changed");

    chk_neg_sample: assert property (
        @(negedge sys_clk_in) disable iff (!rstn_in)
        1'b1 |=> ctl_neg_reg == $past(ctl_in))
        else $error("control not captured on falling edge");
endmodule : nco_phase_mod_sine_lookup

/* File: dv/dac_sink_model.sv */
`timescale 1ns/1ps
module dac_sink_model (
    input  wire logic               sys_clk_in,
    input  wire logic               rstn_in,
    input  wire logic               stall_in,
    input  wire logic               valid_in,
    input  wire nco_pkg::dac_word_t sample_in,
    output logic                    ready_out,
    output nco_pkg::dac_word_t      last_out,
    output nco_pkg::dac_word_t      prev_out,
    output logic [31:0]             taken_out
);
    // Ready low while stalled
    assign ready_out = ~stall_in;
    // Takes one 10-bit word per accepted edge
    always_ff @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            last_out  <= nco_pkg::DAC_CLEAR;
            prev_out  <= nco_pkg::DAC_CLEAR;
            taken_out <= 32'h0;
        end else if (valid_in && ready_out) begin
            prev_out  <= last_out;
            last_out  <= sample_in;
            taken_out <= taken_out + 32'h1;
        end
    end
endmodule : dac_sink_model

/* File: dv/nco_phase_mod_sine_lookup_test.sv */
`timescale 1ns/1ps
module nco_phase_mod_sine_lookup_test;
    logic               sys_clk_in = 1'b0;
    logic               rstn_in    = 1'b0;
    nco_pkg::nco_ctl_t  ctl        = nco_pkg::CTL_CLEAR;
    logic               bypass     = 1'b0;
    logic               stall      = 1'b0;
    logic               ready;
    logic               valid;
    nco_pkg::dac_word_t sample;
    nco_pkg::dac_word_t last_w;
    nco_pkg::dac_word_t prev_w;
    logic [31:0]        taken;
    int                 err_total  = 0;
    int                 n_compared = 0;

    always #20 sys_clk_in = ~sys_clk_in;

    nco_phase_mod_sine_lookup nco_phase_mod_sine_lookup_inst (
        .sys_clk_in(sys_clk_in), .rstn_in(rstn_in), .ctl_in(ctl), .sine_bypass_in(bypass),
        .dac_ready_in(ready), .dac_sample_out(sample), .dac_valid_out(valid));
    dac_sink_model dac_sink_model_inst (
        .sys_clk_in(sys_clk_in), .rstn_in(rstn_in), .stall_in(stall), .valid_in(valid),
        .sample_in(sample), .ready_out(ready), .last_out(last_w), .prev_out(prev_w),
        .taken_out(taken));

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            err_total++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic cycles(input int n);
        repeat (n) @(negedge sys_clk_in);
    endtask : cycles

    task automatic tally_and_finish;
        $display("compared %0d, mismatched %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : tally_and_finish

    task automatic set_point(input nco_pkg::phase_word_t off, input logic sel, input logic byp,
                             input nco_pkg::dac_word_t exp);
        if (sel) ctl.phase_offset_b <= off;
        else ctl.phase_offset_a <= off;
        ctl.phase_reg_select_bit <= sel;
        bypass <= byp;
        cycles(12);
        check(32'(sample), 32'(exp));
    endtask : set_point

    task automatic t_offsets;
        ctl.datapath_reset <= 1'b1;
        cycles(12);
        check(32'(sample), 32'h200);
        ctl.datapath_reset <= 1'b0;
        set_point(12'h100, 1'b0, 1'b1, 10'h040);
        set_point(12'h800, 1'b1, 1'b1, 10'h200);
        set_point(12'h400, 1'b1, 1'b0, 10'h3ff);
        set_point(12'hc00, 1'b1, 1'b0, 10'h001);
        set_point(12'h000, 1'b1, 1'b0, 10'h200);
    endtask : t_offsets

    task automatic t_latency;
        int cnt;
        cnt = 0;
        ctl.phase_offset_b <= 12'h400;
        do begin
            cycles(1);
            cnt++;
        end while (sample === 10'h200 && cnt < 20);
        check(32'(cnt >= nco_pkg::LAT_MIN && cnt <= nco_pkg::LAT_MAX), 32'h1);
        check(32'(sample), 32'h3ff);
        if (cnt >= 20) tally_and_finish();
    endtask : t_latency

    task automatic t_freq;
        nco_pkg::dac_word_t d;
        ctl.phase_offset_b <= 12'h000;
        ctl.freq_increment_a <= 28'h0400000;
        ctl.freq_increment_b <= 28'h0800000;
        bypass <= 1'b1;
        cycles(12);
        check(32'(nco_pkg::dac_word_t'(last_w - prev_w)), 32'h10);
        cycles(70);
        check(32'(nco_pkg::dac_word_t'(last_w - prev_w)), 32'h10);
        ctl.freq_reg_select_bit <= 1'b1;
        for (int i = 0; i < 12; i++) begin
            cycles(1);
            d = last_w - prev_w;
            check(32'(d === 10'h010 || d === 10'h020), 32'h1);
        end
        check(32'(d), 32'h20);
    endtask : t_freq

    task automatic t_stall;
        nco_pkg::dac_word_t hold;
        logic [31:0]        t0;
        stall <= 1'b1;
        cycles(3);
        hold = sample;
        t0 = taken;
        cycles(5);
        check(32'(sample), 32'(hold));
        check(taken, t0);
        check(32'(valid), 32'h1);
        stall <= 1'b0;
        cycles(1);
        check(32'(last_w), 32'(hold));
        // Word parked in the spare comes next, then the frozen pipeline word
        check(32'(sample), 32'(nco_pkg::dac_word_t'(hold + 10'h020)));
        cycles(1);
        check(32'(sample), 32'(nco_pkg::dac_word_t'(hold + 10'h040)));
    endtask : t_stall

    task automatic t_clear;
        bypass <= 1'b0;
        ctl.datapath_reset <= 1'b1;
        cycles(12);
        check(32'(sample), 32'h200);
        check(32'(last_w), 32'h200);
        // Increments survive the reset bit
        bypass <= 1'b1;
        ctl.datapath_reset <= 1'b0;
        cycles(12);
        check(32'(nco_pkg::dac_word_t'(last_w - prev_w)), 32'h20);
    endtask : t_clear

    initial begin
        cycles(1);
        check(32'(sample), 32'h200);
        check(32'(valid), 32'h0);
        cycles(3);
        rstn_in <= 1'b1;
        cycles(10);
        check(32'(valid), 32'h1);
        t_offsets();
        t_latency();
        t_freq();
        t_stall();
        t_clear();
        tally_and_finish();
    end
endmodule : nco_phase_mod_sine_lookup_test
